// ### src/mux_adc_pkg.sv
package mux_adc_pkg;
  // channel and configuration widths
  localparam int CHAN_W = 3;
  localparam int ENTRY_W = 7;
  localparam int PTR_W = 4;
  localparam int DEPTH = 16;
  // stored entry layout: pair, chan[2:0], polarity, gain, last
  localparam int ENT_PAIR = 6;
  localparam int ENT_CH_HI = 5;
  localparam int ENT_CH_LO = 3;
  localparam int ENT_POL = 2;
  localparam int ENT_GAIN = 1;
  localparam int ENT_LAST = 0;
  // conversion timing
  localparam int CONV_TIME_NS = 1400;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_RELEASE_NS = 400;
  // reset values and step sizes
  localparam logic [CHAN_W-1:0] CHAN_ZERO = 3'h0;
  localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
  localparam logic [PTR_W-1:0] PTR_LAST = 4'hf;
  localparam logic [CHAN_W-1:0] SCAN_STEP_SE = 3'h1;
  localparam logic [CHAN_W-1:0] SCAN_STEP_PAIR_SELECT = 3'h2;
  localparam logic [PTR_W-1:0] PTR_STEP = 4'h1;
  // operating modes from the two mode pins
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_SCAN = 2'b01,
    MODE_PROGRAM = 2'b10,
    MODE_RUN = 2'b11
  } op_mode_t;
  // conversion states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_BUSY = 2'b01,
    CONV_HOLD = 2'b10
  } conv_state_t;
endpackage : mux_adc_pkg

// ### src/mux_adc_sequencer_control.sv
`timescale 1ns/100ps
// How it works
// - with select low, a falling sample trigger starts a conversion.
// - trigger activity is ignored while a conversion runs.
// - busy is low throughout each conversion, high when done.
// - select and read low keep result outputs driven; capture at busy rise.
// - with read strobe high, result outputs stay high impedance.
// - tied read/trigger: previous result shown, new one at busy rise.
// - tied read/trigger: each strobe starts a conversion and reads the last result.
// - both mode pins low: channel pins drive mux, config pins set span.
// - direct/scan inputs transparent while load low, latched at its rise.
// - mode 01 is scan: channel pins ignored, pair/gain/polarity honoured.
// - scan with pair low cycles eight single-ended inputs.
// - scan with pair high cycles four differential pairs.
// - pair select is evaluated afresh for every scan conversion.
// - scan counter clears on every change of low-order mode pin.
// - scan counter steps one or two; converted address shown with result.
// - sequencer holds 16 entries of 7 bits including a last flag.
// - an entry reads back as a 7-bit status word on output pins.
// - mode 10 opens the sequencer, holds busy low, blocks conversions.
// - pointer returns to entry zero whenever a mode pin changes.
// - load strobe rise in program mode stores inputs and advances pointer.
// - last write before low mode pin rises ends sequence; wraps after 16.
// - result drivers enabled only while read and select are low.
// - readback read strobe rise tri-states outputs and advances pointer.
module mux_adc_sequencer_control
  import mux_adc_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int CONV_LEN = CONV_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // host control pins
  input wire logic sample_trigger_n,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic load_n,
  input wire logic mode_pin_high_order,
  input wire logic mode_pin_low_order,
  // address and configuration pins
  input wire logic [CHAN_W-1:0] channel_select_in,
  input wire logic pair_select,
  input wire logic gain_range_select,
  input wire logic polarity_select,
  // result from the converter core
  input wire logic [RES_W-1:0] conv_result,
  // result and address outputs
  output logic [RES_W-1:0] data_out,
  output logic [RES_W-1:0] data_oe,
  output logic [CHAN_W-1:0] channel_code_out,
  output logic pair_flag_out,
  output logic addr_oe,
  output logic busy_n,
  // configuration to the analog front end
  output logic [CHAN_W-1:0] mux_channel,
  output logic mux_pair,
  output logic mux_gain,
  output logic mux_polarity,
  output logic conv_sample
);
  localparam int CNT_W = $clog2(CONV_LEN + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_LEN - 1);
  localparam int NPIN = 12;

  // synchronised pins
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins;
  assign pins_raw = {sample_trigger_n, select_n, read_n, load_n, mode_pin_high_order,
                     mode_pin_low_order, channel_select_in, pair_select, gain_range_select, polarity_select};

  pin_sync #(.WIDTH(NPIN)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  wire trig_n = pins[11];
  wire sel_n = pins[10];
  wire rd_n = pins[9];
  wire ld_n = pins[8];
  wire [1:0] mode_pins = pins[7:6];
  wire [CHAN_W-1:0] ch_in = pins[5:3];
  wire pair_in = pins[2];
  wire gain_in = pins[1];
  wire pol_in = pins[0];

  // the synchroniser shows 0 on every pin until it has filled after reset,
  // so edge events and output drivers wait until the edge registers hold real levels;
  // otherwise a trigger pin that idles high would look like a falling edge
  localparam logic [1:0] WARM_DONE = 2'h3;
  logic [1:0] warm_cnt;
  wire settled = warm_cnt == WARM_DONE;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      warm_cnt <= '0;
    end else if (!settled) begin
      warm_cnt <= warm_cnt + 2'h1;
    end
  end

  // previous levels for edge detection
  logic trig_q;
  logic rd_q;
  logic ld_q;
  logic [1:0] mode_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trig_q <= 1'b1;
      rd_q <= 1'b1;
      ld_q <= 1'b1;
      mode_q <= MODE_DIRECT;
    end else begin
      trig_q <= trig_n;
      rd_q <= rd_n;
      ld_q <= ld_n;
      mode_q <= mode_pins;
    end
  end

  // decoded events and modes
  op_mode_t mode;
  assign mode = op_mode_t'(mode_pins);
  wire trig_fall = settled && trig_q && !trig_n;
  wire ld_rise = settled && !ld_q && ld_n;
  wire rd_rise = settled && !rd_q && rd_n;
  wire mode_change = settled && (mode_pins != mode_q);
  wire low_mode_change = settled && (mode_pins[0] != mode_q[0]);
  wire prog_mode = mode == MODE_PROGRAM;
  wire scan_mode = mode == MODE_SCAN;
  wire run_mode = mode == MODE_RUN;

  // configuration latch: transparent while load low
  logic [CHAN_W-1:0] cfg_ch;
  logic cfg_pair;
  logic cfg_gain;
  logic cfg_pol;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ch <= CHAN_ZERO;
      cfg_pair <= 1'b0;
      cfg_gain <= 1'b0;
      cfg_pol <= 1'b0;
    end else if (!ld_n) begin
      cfg_ch <= ch_in;
      cfg_pair <= pair_in;
      cfg_gain <= gain_in;
      cfg_pol <= pol_in;
    end
  end

  // conversion control
  conv_state_t state;
  conv_state_t next_state;
  logic [CNT_W-1:0] conv_cnt;
  wire start_ok = trig_fall && !sel_n && !prog_mode;
  wire conv_done = state == CONV_BUSY && conv_cnt == CONV_LAST;

  // program mode parks the machine in hold, which keeps busy low
  always_comb begin
    next_state = state;
    case (state)
      CONV_IDLE: begin
        if (prog_mode) begin
          next_state = CONV_HOLD;
        end else if (start_ok) begin
          next_state = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        if (conv_done) begin
          next_state = prog_mode ? CONV_HOLD : CONV_IDLE;
        end
      end
      CONV_HOLD: begin
        if (!prog_mode) begin
          next_state = CONV_IDLE;
        end
      end
      default: next_state = CONV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= CONV_IDLE;
      conv_cnt <= '0;
    end else begin
      state <= next_state;
      conv_cnt <= (state == CONV_BUSY) ? conv_cnt + 1'b1 : '0;
    end
  end

  // scan counter
  // cleared on any low mode pin change so each scan pass starts at channel 0
  logic [CHAN_W-1:0] scan_ch;
  wire [CHAN_W-1:0] scan_step = cfg_pair ? SCAN_STEP_PAIR_SELECT : SCAN_STEP_SE;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scan_ch <= CHAN_ZERO;
    end else if (low_mode_change) begin
      scan_ch <= CHAN_ZERO;
    end else if (conv_done && scan_mode) begin
      scan_ch <= scan_ch + scan_step;
    end
  end

  // sequencer pointer and memory
  logic [PTR_W-1:0] seq_ptr;
  logic [PTR_W-1:0] last_ptr;
  logic last_valid;
  logic [ENTRY_W-1:0] seq_rd;
  wire seq_write = prog_mode && ld_rise && rd_n;
  wire seq_read_adv = prog_mode && rd_rise && ld_n;
  wire [ENTRY_W-1:0] seq_wdata = {pair_in, ch_in, pol_in, gain_in, 1'b0};
  // run mode wraps after the last programmed entry
  wire run_wrap = seq_rd[ENT_LAST] || seq_ptr == last_ptr;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seq_ptr <= PTR_ZERO;
      last_ptr <= PTR_LAST;
      last_valid <= 1'b0;
    end else begin
      if (mode_change) begin
        seq_ptr <= PTR_ZERO;
      end else if (seq_write || seq_read_adv) begin
        seq_ptr <= seq_ptr + PTR_STEP;
      end else if (run_mode && conv_done) begin
        seq_ptr <= run_wrap ? PTR_ZERO : seq_ptr + PTR_STEP;
      end
      if (seq_write) begin
        last_ptr <= seq_ptr;
        last_valid <= 1'b1;
      end
    end
  end

  // read and write share the pointer; read data lag it by one clock
  seq_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(seq_write),
    .wr_addr(seq_ptr),
    .wr_data(seq_wdata),
    .rd_addr(seq_ptr),
    .rd_data(seq_rd)
  );

  // end flag follows the last entry written before the low mode pin rose
  wire entry_last = last_valid && seq_ptr == last_ptr;
  wire [ENTRY_W-1:0] status_word = {seq_rd[ENTRY_W-1:1], entry_last};

  // mux selection per mode
  wire [CHAN_W-1:0] sel_ch = scan_mode ? scan_ch : run_mode ? seq_rd[ENT_CH_HI:ENT_CH_LO] : cfg_ch;
  wire sel_pair = run_mode ? seq_rd[ENT_PAIR] : cfg_pair;
  wire sel_gain = run_mode ? seq_rd[ENT_GAIN] : cfg_gain;
  wire sel_pol = run_mode ? seq_rd[ENT_POL] : cfg_pol;

  // output enable decode
  // no drivers until the synchroniser has filled, since it reads the strobes as low
  wire rd_enable = settled && !rd_n && !sel_n;
  // readback drives only the three status pins at the top of the data word
  wire [RES_W-1:0] status_oe = {{ENTRY_W-4{1'b1}}, {RES_W-ENTRY_W+4{1'b0}}};
  wire [RES_W-1:0] next_data_oe = !rd_enable ? '0 : prog_mode ? status_oe : '1;

  // front end, result and address registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mux_channel <= CHAN_ZERO;
      mux_pair <= 1'b0;
      mux_gain <= 1'b0;
      mux_polarity <= 1'b0;
      conv_sample <= 1'b0;
      busy_n <= 1'b1;
      data_out <= '0;
      channel_code_out <= CHAN_ZERO;
      pair_flag_out <= 1'b0;
      data_oe <= '0;
      addr_oe <= 1'b0;
    end else begin
      if (state == CONV_IDLE && next_state == CONV_BUSY) begin
        mux_channel <= sel_ch;
        mux_pair <= sel_pair;
        mux_gain <= sel_gain;
        mux_polarity <= sel_pol;
      end
      conv_sample <= next_state == CONV_BUSY;
      busy_n <= next_state == CONV_IDLE;
      if (conv_done) begin
        data_out <= conv_result;
        channel_code_out <= mux_channel;
        pair_flag_out <= mux_pair;
      end else if (prog_mode) begin
        data_out <= {status_word[2:0], {RES_W-3{1'b0}}};
        channel_code_out <= status_word[5:3];
        pair_flag_out <= status_word[6];
      end
      data_oe <= next_data_oe;
      addr_oe <= rd_enable;
    end
  end
endmodule : mux_adc_sequencer_control

// ### src/pin_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a bundle of pins
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      pin_out <= '0;
    end else begin
      stage1 <= pin_in;
      pin_out <= stage1;
    end
  end
endmodule : pin_sync

// ### src/seq_mem.sv
`timescale 1ns/100ps
// sequencer entry store with registered read
module seq_mem
  import mux_adc_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int AW = PTR_W
) (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // write and registered read
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : seq_mem

// ### tb/adc_chk_assertions.sv
`timescale 1ns/100ps
module adc_chk
  import mux_adc_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int CONV_LEN = CONV_CYCLES
) (
  // clock and reset
  input wire logic sys_clk, rstn,
  // host pins
  input wire logic select_n, read_n, load_n, mode_pin_high_order, mode_pin_low_order,
  input wire logic [CHAN_W-1:0] channel_select_in,
  input wire logic [RES_W-1:0] conv_result,
  // device outputs
  input wire logic [RES_W-1:0] data_out, data_oe,
  input wire logic [CHAN_W-1:0] mux_channel,
  input wire logic addr_oe, busy_n, conv_sample
);
  localparam int LO = CONV_LEN - 1;
  localparam int HI = CONV_LEN + 1;
  int run;
  // mode and read decode
  wire logic prog = mode_pin_high_order & ~mode_pin_low_order;
  wire logic dir = ~mode_pin_high_order & ~mode_pin_low_order;
  wire logic live = dir & ~load_n;
  wire logic rd = ~read_n & ~select_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // cycles spent converting
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) run <= 0;
    else run <= conv_sample ? run + 1 : 0;
  end
  AST_BUSY_LOW: assert property (conv_sample |-> !busy_n)
    else $error("busy high in conversion");
  AST_CONV_LEN: assert property ($fell(conv_sample) |-> run inside {[LO:HI]})
    else $error("conversion length off");
  AST_OE_OFF: assert property ((read_n | select_n)[*4] |-> !addr_oe && data_oe == '0)
    else $error("driving without read");
  AST_OE_ON: assert property ((rd & dir)[*4] |-> addr_oe && &data_oe)
    else $error("not driving on read");
  AST_PROG_OE: assert property ((rd & prog)[*4] |-> addr_oe && data_oe == {3'h7, {(RES_W-3){1'b0}}})
    else $error("readback drivers wrong");
  AST_PROG_BUSY: assert property (prog[*4] |-> !busy_n)
    else $error("busy high in program mode");
  AST_PROG_NOCONV: assert property ($rose(conv_sample) |-> !($past(prog, 3) && $past(prog, 4)))
    else $error("conversion in program mode");
  AST_RESULT: assert property ($rose(busy_n) && $past(conv_sample) |-> data_out == $past(conv_result))
    else $error("result not updated");
  AST_DIRECT: assert property ($rose(conv_sample) && live && $stable(channel_select_in)
    |-> mux_channel == channel_select_in) else $error("direct channel wrong");
  // main scenarios reached
  cover property ($rose(busy_n) && dir);
  cover property ((rd & prog)[*4]);
  cover property ($fell(conv_sample) && !dir);
endmodule : adc_chk

bind mux_adc_sequencer_control adc_chk #(.RES_W(RES_W), .CONV_LEN(CONV_LEN)) u_adc_chk (
  .sys_clk, .rstn, .select_n, .read_n, .load_n, .mode_pin_high_order, .mode_pin_low_order,
  .channel_select_in, .conv_result, .data_out, .data_oe, .mux_channel, .addr_oe, .busy_n, .conv_sample
);

// ### tb/host.sv
`timescale 1ns/100ps
module host (
  // clock and device status
  input wire logic sys_clk, busy_n, tie,
  input wire logic [11:0] data_in,
  // device pins
  output logic trig_n, sel_n, rd_n, ld_n, m_hi, m_lo, pair, gain, pol,
  output logic [2:0] chan
);
  bit hung = 1'b0;
  // selected, read off, inputs transparent, direct mode
  initial begin
    {trig_n, sel_n, rd_n, ld_n, m_hi, m_lo} = 6'b101000;
    {pair, chan, pol, gain} = 6'h00;
  end
  // configuration pins and load strobe, then settle
  task automatic cfg(input logic [5:0] e, input logic l);
    @(posedge sys_clk);
    {pair, chan, pol, gain} <= e;
    ld_n <= l;
    repeat (6) @(posedge sys_clk);
  endtask : cfg
  // mode pins; every change restarts the pointer
  task automatic mode(input logic [1:0] m);
    @(posedge sys_clk);
    {m_hi, m_lo} <= m;
    repeat (6) @(posedge sys_clk);
  endtask : mode
  // read strobe level
  task automatic rdst(input logic v);
    @(posedge sys_clk);
    rd_n <= v;
    repeat (6) @(posedge sys_clk);
  endtask : rdst
  // device select level
  task automatic chip_sel(input logic v);
    @(posedge sys_clk);
    sel_n <= v;
    repeat (6) @(posedge sys_clk);
  endtask : chip_sel
  // trigger pulse that must start nothing; reports whether busy stayed high
  task automatic pulse(output logic stayed);
    stayed = 1'b1;
    @(posedge sys_clk);
    trig_n <= 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      stayed = stayed & busy_n;
    end
    trig_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : pulse
  // one conversion; a tied strobe keeps the trigger low until busy rises
  task automatic convert(output logic [11:0] mid);
    int n;
    @(posedge sys_clk);
    trig_n <= 1'b0;
    for (n = 0; n < 9 && busy_n; n++) @(posedge sys_clk);
    if (n == 9) hung = 1'b1;
    if (!tie) trig_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    trig_n <= 1'b0;
    mid = data_in;
    for (n = 0; n < 300 && !busy_n; n++) @(posedge sys_clk);
    if (n == 300) hung = 1'b1;
    trig_n <= 1'b1;
  endtask : convert
endmodule : host

// ### tb/mux_adc_sequencer_control_tb.sv
`timescale 1ns/100ps
module mux_adc_sequencer_control_tb;
  import mux_adc_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic tie = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic [11:0] mid, prev;
  logic [31:0] seed = 32'h30a5a9e2;
  logic [5:0] e, ent [3];
  logic [2:0] cnt;
  logic quiet;
  int n_errors = 0;
  int tests_run = 0;
  wire logic trig_n, sel_n, rd_n, ld_n, m_hi, m_lo, pair, gain, pol, pflag, busy_n;
  wire logic [2:0] chan, code;
  wire logic [11:0] dout, doe;
  wire logic aoe, csamp, mpair, mgain, mpol;
  wire logic [2:0] mchan;
  always #5 sys_clk = ~sys_clk;
  mux_adc_sequencer_control #(.CONV_LEN(12)) u_mux_adc_sequencer_control (
    .sys_clk, .rstn, .sample_trigger_n(trig_n), .select_n(sel_n), .read_n(tie ? trig_n : rd_n),
    .load_n(ld_n), .mode_pin_high_order(m_hi), .mode_pin_low_order(m_lo), .channel_select_in(chan),
    .pair_select(pair), .gain_range_select(gain), .polarity_select(pol), .conv_result,
    .data_out(dout), .data_oe(doe), .channel_code_out(code), .pair_flag_out(pflag), .addr_oe(aoe),
    .busy_n, .mux_channel(mchan), .mux_pair(mpair), .mux_gain(mgain), .mux_polarity(mpol), .conv_sample(csamp)
  );
  host h (.sys_clk, .busy_n, .tie, .data_in(dout), .trig_n, .sel_n, .rd_n, .ld_n, .m_hi, .m_lo,
    .pair, .gain, .pol, .chan);
  // xorshift stimulus source
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // scan address after a conversion
  function automatic logic [2:0] scan_step(input logic [2:0] c, input logic p);
    return c + (p ? 3'h2 : 3'h1);
  endfunction : scan_step
  // compare and count
  task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  // convert a fresh random result and check what comes back
  // x is the expected {pair, channel, polarity, gain} of the conversion
  task automatic conv(input logic [5:0] x);
    @(posedge sys_clk);
    seed = xs(seed);
    conv_result <= seed[11:0];
    h.convert(mid);
    if (h.hung) print_verdict();
    repeat (6) @(posedge sys_clk);
    check_val(dout, seed[11:0]);
    check_val({9'h000, code}, {9'h000, x[4:2]});
    check_val({11'h000, pflag}, {11'h000, x[5]});
    check_val({8'h00, mpair, mchan}, {8'h00, x[5:2]});
    check_val({10'h000, mpol, mgain}, {10'h000, x[1:0]});
    check_val({10'h000, busy_n, csamp}, 12'h002);
    if (tie) check_val(mid, prev);
    prev = seed[11:0];
  endtask : conv
  task automatic print_verdict;
    if (h.hung) n_errors++;
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    h.cfg(6'h00, 1'b0);
    check_val(doe, 12'h000);
    check_val({11'h000, aoe}, 12'h000);
    for (int i = 0; i < 6; i++) begin
      e = seed[21:16];
      h.cfg(e, 1'b0);
      conv(e);
    end
    // deselected: trigger and read strobe are ignored
    h.chip_sel(1'b1);
    h.pulse(quiet);
    check_val({11'h000, quiet}, 12'h001);
    h.rdst(1'b0);
    check_val({doe[11:1], aoe}, 12'h000);
    h.rdst(1'b1);
    h.chip_sel(1'b0);
    h.rdst(1'b0);
    check_val(doe, 12'hfff);
    check_val({11'h000, aoe}, 12'h001);
    h.rdst(1'b1);
    // latched configuration survives pin changes
    h.cfg(6'h2c, 1'b0);
    h.cfg(6'h2c, 1'b1);
    h.cfg(6'h14, 1'b1);
    conv(6'h2c);
    h.cfg(6'h14, 1'b0);
    // strobe tied to trigger
    @(posedge sys_clk);
    tie <= 1'b1;
    conv(6'h14);
    conv(6'h14);
    @(posedge sys_clk);
    tie <= 1'b0;
    // reset in mid-run: outputs clear, and no false start once it lifts
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check_val(dout, 12'h000);
    check_val({doe[11:1], aoe}, 12'h000);
    check_val({11'h000, busy_n}, 12'h001);
    rstn <= 1'b1;
    h.cfg(6'h14, 1'b0);
    check_val({10'h000, busy_n, csamp}, 12'h002);
    // scan passes, pair select random on even addresses in the second
    for (int k = 0; k < 2; k++) begin
      h.mode(2'b00);
      h.mode(2'b01);
      cnt = 3'h0;
      for (int i = 0; i < 9; i++) begin
        e = seed[21:16];
        e[5] = e[5] & ~cnt[0] & k[0];
        h.cfg(e, 1'b0);
        conv({e[5], cnt, e[1:0]});
        cnt = scan_step(cnt, e[5]);
      end
    end
    // program three entries, then read them back
    h.cfg(6'h00, 1'b1);
    h.mode(2'b10);
    check_val({11'h000, busy_n}, 12'h000);
    h.pulse(quiet);
    check_val({11'h000, quiet}, 12'h000);
    for (int i = 0; i < 3; i++) begin
      ent[i] = seed[21:16];
      seed = xs(seed);
      h.cfg(ent[i], 1'b0);
      h.cfg(ent[i], 1'b1);
    end
    h.mode(2'b11);
    // run the sequence once and wrap back to its first entry
    for (int i = 0; i < 4; i++) begin
      conv(ent[i % 3]);
    end
    h.mode(2'b10);
    for (int i = 0; i < 3; i++) begin
      h.rdst(1'b0);
      check_val({5'h00, pflag, code, dout[11:9]}, {5'h00, ent[i], i == 2});
      check_val(doe, 12'he00);
      h.rdst(1'b1);
      check_val({doe[11:1], aoe}, 12'h000);
    end
    h.mode(2'b00);
    print_verdict();
  end
endmodule : mux_adc_sequencer_control_tb
